/* design/sdsc_pkg.sv */
// Package: register map, field layout and types of the SDRAM sequencer configuration block
package sdsc_pkg;

  // ==========================================================================
  // Register offsets (byte addresses)
  localparam logic [11:0] SEQ_STORE_BASE   = 12'h100;
  localparam logic [11:0] SEQ_STORE_LAST   = 12'h1FC;
  localparam logic [11:0] MODE_IMAGE_OFS   = 12'h200;
  localparam logic [11:0] POWERUP_WAIT_OFS = 12'h204;
  localparam logic [11:0] REFRESH_INT_OFS  = 12'h208;
  localparam logic [11:0] CTRL_FLAGS_OFS   = 12'h214;
  localparam logic [11:0] CMD_STATUS_OFS   = 12'h218;

  // ==========================================================================
  // Field positions
  localparam int ADDR_ARG_MSB_LARGE = 12;
  localparam int ADDR_ARG_MSB_SMALL = 11;
  localparam int ADDR_ARG_LSB       = 7;
  localparam int OP_MSB             = 6;
  localparam int OP_LSB             = 4;
  localparam int RAS_BIT            = 3;
  localparam int CAS_BIT            = 2;
  localparam int WE_BIT             = 1;
  localparam int WBURST_BIT         = 9;
  localparam int CL_MSB             = 6;
  localparam int CL_LSB             = 4;
  localparam int ORDER_BIT          = 3;
  localparam int BURST_LENGTH_FIELD_MSB           = 2;
  localparam int BURST_LENGTH_FIELD_LSB           = 0;
  localparam int BUSY_BIT           = 0;

  // Bits of the mode image that software may set (12:10 and 8:7 read zero)
  localparam logic [12:0] MODE_WRITABLE = 13'h027F;

  // ==========================================================================
  // Reset values
  localparam logic [12:0] MODE_RESET    = 13'h0033;
  localparam logic [15:0] POWERUP_RESET = 16'h4E20;
  localparam logic [15:0] REFRESH_RESET = 16'h0640;

  // ==========================================================================
  // Timing figures at the nominal clock, and the large store depth
  localparam int CLK_MHZ         = 40;
  localparam int POWERUP_TIME_US = 200;
  localparam int REFRESH_TIME_US = 16;
  localparam int POWERUP_CYCLES  = POWERUP_TIME_US * CLK_MHZ;
  localparam int REFRESH_CYCLES  = REFRESH_TIME_US * CLK_MHZ;
  localparam int SEQ_DEPTH_LARGE = 64;

  // ==========================================================================
  // Types
  typedef enum logic [2:0] {
    SDSC_OP_RUN, SDSC_OP_RET, SDSC_OP_CALL, SDSC_OP_LOOP,
    SDSC_OP_CODE4, SDSC_OP_CODE5, SDSC_OP_CODE6, SDSC_OP_CODE7
  } sdsc_op_t;

  typedef struct packed {
    logic       ras_n;
    logic       cas_n;
    logic       we_n;
  } sdsc_cmd_t;

  typedef struct packed {
    logic       write_burst_select;
    logic [2:0] cas_latency_field;
    logic       burst_order_select;
    logic [2:0] burst_length_field;
  } sdsc_mode_t;

  typedef struct packed {
    logic       valid;
    sdsc_op_t   op;
    logic [5:0] addr_arg;
    sdsc_cmd_t  cmd;
  } sdsc_step_t;

endpackage : sdsc_pkg

/* design/sdsc_timer.sv */
// Power-up wait and refresh interval timer
`timescale 1ns/1ps
module sdsc_timer (
  input  wire logic        clk,          // System clock
  input  wire logic        rst_b,        // Async reset, active low
  input  wire logic        ce,           // Clock enable
  input  wire logic [15:0] init_period,  // Power-up wait in clocks
  input  wire logic [15:0] rfsh_period,  // Refresh interval in clocks
  output logic             init_done,    // Power-up wait over
  output logic             rfsh_req      // One-cycle refresh request
);
  import sdsc_pkg::*;

  logic [15:0] count;

  // ==========================================================================
  // Counter: first the power-up wait, then repeating refresh intervals
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      count     <= 16'h0000;
      init_done <= 1'b0;
      rfsh_req  <= 1'b0;
    end else if (ce) begin
      rfsh_req <= 1'b0;
      if (!init_done) begin
        if (count + 16'h0001 >= init_period) begin
          init_done <= 1'b1;
          count     <= 16'h0000;
        end else begin
          count <= count + 16'h0001;
        end
      end else if (count + 16'h0001 >= rfsh_period) begin
        rfsh_req <= 1'b1;
        count    <= 16'h0000;
      end else begin
        count <= count + 16'h0001;
      end
    end
  end

endmodule // sdsc_timer

/* design/sdsc_top.sv */
// SDRAM sequencer configuration block: AHB-Lite registers, microcode store, sequencer
// Behaviour
// - Word bits 12:7 (or 11:7) hold branch address
// - Bits 6:4 decode run, ret, call, loop, ...
// - Bits 3,2,1 give RAS, CAS, WE levels
// - Store of 64/32 words from 0x100
// - Mode image loaded to SDRAM; reserved bits zero
// - Bit 9 selects burst or single writes
// - Bit 3 selects interleaved or sequential order
// - Bits 2:0 burst length, reset code 3
// - Power-up wait count, default 0x4E20
// - Refresh interval count, default 0x0640
// - Busy bit set during microprogram upload
//
// Decided for this implementation: the AHB-Lite register port.
`timescale 1ns/1ps
module sdsc_top #(
  parameter int SEQ_DEPTH = sdsc_pkg::SEQ_DEPTH_LARGE  // Store words: 64 or 32
) (
  input  wire logic                 clk,           // System clock
  input  wire logic                 rst_b,         // Async reset, active low
  input  wire logic                 ce,            // Clock enable, freezes state
  input  wire logic                 hsel,          // AHB slave select
  input  wire logic [11:0]          haddr,         // AHB address
  input  wire logic [1:0]           htrans,        // AHB transfer type
  input  wire logic                 hwrite,        // AHB write
  input  wire logic [2:0]           hsize,         // AHB size
  input  wire logic [31:0]          hwdata,        // AHB write data
  input  wire logic                 hready,        // AHB bus ready
  output logic [31:0]               hrdata,        // AHB read data
  output logic                      hreadyout,     // AHB slave ready
  output logic                      hresp,         // AHB response, always OKAY
  output sdsc_pkg::sdsc_cmd_t       sdram_cmd,     // SDRAM command levels
  output logic                      sdram_cmd_valid, // Command issued this cycle
  output logic [5:0]                seq_branch_addr, // Address argument of step
  output sdsc_pkg::sdsc_op_t        seq_op,        // Decoded step operation
  output sdsc_pkg::sdsc_mode_t      mode_out,      // Mode image for MRS load
  output logic                      init_done,     // Power-up wait over
  output logic                      seq_active     // Sequence running
);
  import sdsc_pkg::*;

  localparam int AW    = $clog2(SEQ_DEPTH);
  localparam int AMSB  = (SEQ_DEPTH > 32) ? ADDR_ARG_MSB_LARGE : ADDR_ARG_MSB_SMALL;

  typedef enum logic [1:0] {S_IDLE, S_RUN, S_DONE} sdsc_state_t;
  typedef enum logic [2:0] {
    SEL_NONE, SEL_STORE, SEL_MODE, SEL_PWAIT, SEL_RFSH, SEL_FLAGS, SEL_STATUS
  } sdsc_sel_t;

  // ==========================================================================
  // Storage
  logic [12:0]     store [SEQ_DEPTH];
  logic [12:0]     mode_image;
  logic [15:0]     powerup_wait_count;
  logic [15:0]     refresh_interval_count;
  logic            busy_flag;
  logic            rfsh_req;
  logic            rfsh_pend;
  sdsc_state_t     state;
  logic [AW-1:0]   pc;
  logic [AW-1:0]   ret_pc;
  logic [12:0]     step_word;
  sdsc_mode_t      mode_latched;

  // Bus data-phase registers, bus decode signals and the decoded step
  logic            dp_write;
  logic [11:0]     dp_addr;
  logic            ahb_take;
  logic [11:0]     rd_addr;
  sdsc_sel_t       wr_sel;
  sdsc_sel_t       rd_sel;
  sdsc_step_t      step;

  // ==========================================================================
  // Address decode helpers
  function automatic logic is_store(input logic [11:0] a);
    is_store = (a >= SEQ_STORE_BASE) &&
               (a <= SEQ_STORE_BASE + 12'((SEQ_DEPTH - 1) * 4));
  endfunction

  function automatic logic [AW-1:0] store_index(input logic [11:0] a);
    store_index = AW'((a - SEQ_STORE_BASE) >> 2);
  endfunction

  // Register select, shared by the write and the read path
  function automatic sdsc_sel_t reg_sel(input logic [11:0] a);
    if (is_store(a)) begin
      reg_sel = SEL_STORE;
    end else if (a == MODE_IMAGE_OFS) begin
      reg_sel = SEL_MODE;
    end else if (a == POWERUP_WAIT_OFS) begin
      reg_sel = SEL_PWAIT;
    end else if (a == REFRESH_INT_OFS) begin
      reg_sel = SEL_RFSH;
    end else if (a == CTRL_FLAGS_OFS) begin
      reg_sel = SEL_FLAGS;
    end else if (a == CMD_STATUS_OFS) begin
      reg_sel = SEL_STATUS;
    end else begin
      reg_sel = SEL_NONE;
    end
  endfunction

  // Field split of one microcode word
  function automatic sdsc_step_t decode_word(input logic [12:0] w, input logic run);
    sdsc_step_t s;
    s.valid    = run;
    s.op       = sdsc_op_t'(w[OP_MSB:OP_LSB]);
    s.addr_arg = 6'(w[AMSB:ADDR_ARG_LSB]);
    s.cmd      = '{ras_n: w[RAS_BIT], cas_n: w[CAS_BIT], we_n: w[WE_BIT]};
    return s;
  endfunction

  // ==========================================================================
  // AHB-Lite slave: zero-wait, always OKAY
  assign hreadyout = 1'b1;
  assign hresp     = 1'b0;
  assign ahb_take  = hsel && hready && htrans[1];
  assign rd_addr   = {haddr[11:2], 2'b00};
  assign wr_sel    = reg_sel(dp_addr);
  assign rd_sel    = reg_sel(rd_addr);

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      dp_write <= 1'b0;
      dp_addr  <= 12'h000;
    end else if (ce) begin
      dp_write <= ahb_take && hwrite;
      if (ahb_take) begin
        dp_addr <= {haddr[11:2], 2'b00};
      end
    end
  end

  // Microcode store has no reset: contents undefined until loaded
  always_ff @(posedge clk) begin
    if (ce && dp_write && wr_sel == SEL_STORE) begin
      store[store_index(dp_addr)] <= hwdata[12:0];
    end
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      mode_image <= MODE_RESET;
    end else if (ce && dp_write && wr_sel == SEL_MODE) begin
      mode_image <= hwdata[12:0] & MODE_WRITABLE;
    end
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      powerup_wait_count <= POWERUP_RESET;
    end else if (ce && dp_write && wr_sel == SEL_PWAIT) begin
      powerup_wait_count <= hwdata[15:0];
    end
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      refresh_interval_count <= REFRESH_RESET;
    end else if (ce && dp_write && wr_sel == SEL_RFSH) begin
      refresh_interval_count <= hwdata[15:0];
    end
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      busy_flag <= 1'b0;
    end else if (ce && dp_write && wr_sel == SEL_FLAGS) begin
      busy_flag <= hwdata[BUSY_BIT];
    end
  end

  // Read data registered on the address phase, so it stands in the data phase
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      hrdata <= 32'h0000_0000;
    end else if (ce && ahb_take && !hwrite) begin
      case (rd_sel)
        SEL_STORE: begin
          hrdata <= {19'h00000, store[store_index(rd_addr)]};
        end
        SEL_MODE: begin
          hrdata <= {19'h00000, mode_image};
        end
        SEL_PWAIT: begin
          hrdata <= {16'h0000, powerup_wait_count};
        end
        SEL_RFSH: begin
          hrdata <= {16'h0000, refresh_interval_count};
        end
        SEL_FLAGS: begin
          hrdata <= {31'h0000_0000, busy_flag};
        end
        SEL_STATUS: begin
          hrdata <= {28'h0000000, init_done, seq_active, rfsh_pend, (state == S_DONE)};
        end
        default: begin
          hrdata <= 32'h0000_0000;
        end
      endcase
    end
  end

  // ==========================================================================
  // Power-up and refresh timing
  sdsc_timer i_sdsc_timer (
    .clk         (clk),
    .rst_b       (rst_b),
    .ce          (ce),
    .init_period (powerup_wait_count),
    .rfsh_period (refresh_interval_count),
    .init_done   (init_done),
    .rfsh_req    (rfsh_req)
  );

  // Pending refresh: set wins over the clear taken at sequence start
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      rfsh_pend <= 1'b0;
    end else if (ce) begin
      if (rfsh_req) begin
        rfsh_pend <= 1'b1;
      end else if (state == S_IDLE && !busy_flag && init_done) begin
        rfsh_pend <= 1'b0;
      end
    end
  end

  // ==========================================================================
  // Sequencer: starts at word 0 on a refresh, never while uploading
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      state        <= S_IDLE;
      pc           <= '0;
      ret_pc       <= '0;
      step_word    <= 13'h0000;
      mode_latched <= '0;
    end else if (ce) begin
      case (state)
        S_IDLE: begin
          if (init_done && rfsh_pend && !busy_flag) begin
            state        <= S_RUN;
            pc           <= '0;
            mode_latched <= '{write_burst_select: mode_image[WBURST_BIT],
                              cas_latency_field:  mode_image[CL_MSB:CL_LSB],
                              burst_order_select: mode_image[ORDER_BIT],
                              burst_length_field: mode_image[BURST_LENGTH_FIELD_MSB:BURST_LENGTH_FIELD_LSB]};
            step_word    <= store[0];
          end
        end
        S_RUN: begin
          step_word <= store[pc + AW'(1)];
          pc        <= pc + AW'(1);
          case (step.op)
            SDSC_OP_RET: begin
              state <= S_DONE;
            end
            SDSC_OP_CALL: begin
              ret_pc    <= pc + AW'(1);
              pc        <= AW'(step.addr_arg);
              step_word <= store[AW'(step.addr_arg)];
            end
            SDSC_OP_LOOP: begin
              pc        <= AW'(step.addr_arg);
              step_word <= store[AW'(step.addr_arg)];
            end
            default: begin
            end
          endcase
          // Codes 4 to 7 advance like run, so they end the store as well
          if (pc == AW'(SEQ_DEPTH - 1) &&
              step.op != SDSC_OP_CALL && step.op != SDSC_OP_LOOP) begin
            state <= S_DONE;
          end
        end
        S_DONE: begin
          state <= S_IDLE;
        end
        default: begin
          state <= S_IDLE;
        end
      endcase
    end
  end

  // ==========================================================================
  // Command outputs from flip-flops
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      sdram_cmd       <= '{ras_n: 1'b1, cas_n: 1'b1, we_n: 1'b1};
      sdram_cmd_valid <= 1'b0;
      seq_branch_addr <= 6'h00;
      seq_op          <= SDSC_OP_RUN;
    end else if (ce) begin
      sdram_cmd_valid <= step.valid;
      if (step.valid) begin
        sdram_cmd       <= step.cmd;
        seq_branch_addr <= step.addr_arg;
        seq_op          <= step.op;
      end else begin
        sdram_cmd <= '{ras_n: 1'b1, cas_n: 1'b1, we_n: 1'b1};
      end
    end
  end

  assign step       = decode_word(step_word, state == S_RUN);
  assign mode_out   = mode_latched;
  assign seq_active = (state == S_RUN);

endmodule // sdsc_top

/* sim/sdsc_sdram_model.sv */
// Behavioural external SDRAM: logs commands, holds the mode on a load
`timescale 1ns/1ps
module sdsc_sdram_model (
  input wire logic             clk,             // System clock
  input wire logic             rst_b,           // Controller reset
  input sdsc_pkg::sdsc_cmd_t   sdram_cmd,       // Command levels
  input wire logic             sdram_cmd_valid, // Command issued
  input sdsc_pkg::sdsc_mode_t  mode_out         // Mode image
);
  import sdsc_pkg::*;
  sdsc_cmd_t  cmd_log[$];  // Commands in order of issue
  sdsc_mode_t mrs_image;   // Mode held by the device
  int         bad_cl = 0;  // Loads with an unusable latency
  always @(posedge clk) begin
    if (rst_b && sdram_cmd_valid === 1'b1) begin
      cmd_log.push_back(sdram_cmd);
      if (sdram_cmd === 3'h0) begin
        mrs_image = mode_out;
        if (mode_out.cas_latency_field != 3'h2 && mode_out.cas_latency_field != 3'h3)
          bad_cl++;
      end
    end
  end
endmodule // sdsc_sdram_model

/* sim/sdsc_top_asserts.sv */
// Port checker for the SDRAM sequencer configuration block
`timescale 1ns/1ps
module sdsc_top_asserts #(
  parameter int SEQ_DEPTH = 64  // Store words
) (
  input wire logic             clk,             // System clock
  input wire logic             rst_b,           // Async reset
  input wire logic             ce,              // Clock enable
  input wire logic             hsel,            // Slave select
  input wire logic [1:0]       htrans,          // Transfer type
  input wire logic             hwrite,          // Write
  input wire logic             hready,          // Bus ready
  input wire logic [31:0]      hrdata,          // Read data
  input wire logic             hreadyout,       // Slave ready
  input wire logic             hresp,           // Response
  input sdsc_pkg::sdsc_cmd_t   sdram_cmd,       // Command levels
  input wire logic             sdram_cmd_valid, // Command issued
  input sdsc_pkg::sdsc_mode_t  mode_out,        // Mode image
  input wire logic             init_done,       // Wait over
  input wire logic             seq_active       // Sequence running
);
  import sdsc_pkg::*;
  logic rd_take;
  assign rd_take = hsel && hready && htrans[1] && !hwrite && ce;
  default clocking dc @(posedge clk); endclocking
  default disable iff (!rst_b);
  // ======================================================================
  // Assertions
  bus_okay_a: assert property (hreadyout && !hresp)
    else $error("slave not ready or not okay");
  rdata_width_a: assert property (hrdata[31:16] == 16'h0000)
    else $error("read data upper half not zero");
  rdata_hold_a: assert property (!$past(rd_take) |-> $stable(hrdata))
    else $error("read data changed without a read");
  init_gate_a: assert property (sdram_cmd_valid |-> init_done)
    else $error("command before power-up wait over");
  active_init_a: assert property (seq_active |-> init_done)
    else $error("sequence before power-up wait over");
  init_hold_a: assert property (init_done |=> init_done)
    else $error("power-up done dropped");
  valid_step_a: assert property (sdram_cmd_valid |-> $past(seq_active))
    else $error("command without a running step");
  mode_steady_a: assert property (seq_active && $past(seq_active) |-> $stable(mode_out))
    else $error("mode image changed inside a sequence");
  cover property ($rose(init_done));
  cover property (sdram_cmd_valid && sdram_cmd == 3'h0);
  cover property ($rose(seq_active));
endmodule // sdsc_top_asserts

bind sdsc_top sdsc_top_asserts #(.SEQ_DEPTH(SEQ_DEPTH)) i_sdsc_top_asserts (
  .clk(clk), .rst_b(rst_b), .ce(ce), .hsel(hsel), .htrans(htrans), .hwrite(hwrite),
  .hready(hready), .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp),
  .sdram_cmd(sdram_cmd), .sdram_cmd_valid(sdram_cmd_valid), .mode_out(mode_out),
  .init_done(init_done), .seq_active(seq_active));

/* sim/test_sdram_sequencer_config.sv */
// Bench: register access over AHB-Lite and microcode sequence runs
`timescale 1ns/1ps
module test_sdram_sequencer_config;
  import sdsc_pkg::*;
  // ======================================================================
  // Signals
  logic        clk = 1'b0, rst_b = 1'b0, ce = 1'b1, hsel = 1'b0, hwrite = 1'b0;
  logic [11:0] haddr = 12'h000;
  logic [1:0]  htrans = 2'h0;
  logic [2:0]  hsize = 3'h2;
  logic [31:0] hwdata = 32'h0, hrdata, rd;
  logic        hready, hreadyout, hresp, sdram_cmd_valid, init_done, seq_active, prev_act;
  logic [5:0]  seq_branch_addr;
  sdsc_cmd_t   sdram_cmd;
  sdsc_op_t    seq_op;
  sdsc_mode_t  mode_out;
  logic [8:0]  steps[$];
  time         starts[$];
  int          fails = 0, compares = 0;
  int          idx[8] = '{0, 1, 2, 3, 4, 6, 8, 9};
  sdsc_op_t    ops[8] = '{SDSC_OP_CODE4, SDSC_OP_CODE5, SDSC_OP_CODE6, SDSC_OP_CODE7,
                          SDSC_OP_LOOP, SDSC_OP_CALL, SDSC_OP_RUN, SDSC_OP_RET};
  logic [5:0]  args[8] = '{6'h0, 6'h0, 6'h0, 6'h0, 6'h6, 6'h8, 6'h0, 6'h0};
  assign hready = hreadyout;
  always #12.5 clk = ~clk;
  sdsc_top i_sdsc_top (.clk(clk), .rst_b(rst_b), .ce(ce), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hready),
    .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp), .sdram_cmd(sdram_cmd),
    .sdram_cmd_valid(sdram_cmd_valid), .seq_branch_addr(seq_branch_addr), .seq_op(seq_op),
    .mode_out(mode_out), .init_done(init_done), .seq_active(seq_active));
  sdsc_sdram_model i_sdsc_sdram_model (.clk(clk), .rst_b(rst_b), .sdram_cmd(sdram_cmd),
    .sdram_cmd_valid(sdram_cmd_valid), .mode_out(mode_out));
  // ======================================================================
  // Monitors of executed steps and sequence starts
  always @(posedge clk) begin
    prev_act <= seq_active;
    if (sdram_cmd_valid === 1'b1)
      steps.push_back({seq_op, seq_branch_addr});
    if (seq_active === 1'b1 && prev_act === 1'b0)
      starts.push_back($time);
  end
  // ======================================================================
  // Tasks
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    compares++;
    if (seen !== exp) begin
      fails++;
      $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic bus(input logic wr, input logic [11:0] a, input logic [31:0] wd);
    @(posedge clk);
    hsel <= 1'b1;
    htrans <= 2'h2;
    haddr <= a;
    hwrite <= wr;
    do @(posedge clk); while (hreadyout !== 1'b1);
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= wd;
    do @(posedge clk); while (hreadyout !== 1'b1);
    rd = hrdata;
  endtask
  task automatic rdc(input logic [11:0] a, input logic [31:0] exp);
    bus(1'b0, a, 32'h0);
    chk(rd, exp);
  endtask
  task automatic tally_and_finish;
    $display("compares=%0d fails=%0d", compares, fails);
    if (fails == 0 && compares > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask
  // ======================================================================
  // Watchdog
  initial begin
    #100000;
    fails++;
    tally_and_finish;
  end
  // ======================================================================
  // Tests
  initial begin
    repeat (2) @(posedge clk);
    rst_b <= 1'b1;
    rdc(POWERUP_WAIT_OFS, 32'h4E20);
    rdc(CTRL_FLAGS_OFS, 32'h0);
    bus(1'b1, POWERUP_WAIT_OFS, 32'd60);
    bus(1'b1, CTRL_FLAGS_OFS, 32'h1);
    rdc(CTRL_FLAGS_OFS, 32'h1);
    rdc(REFRESH_INT_OFS, 32'h0640);
    bus(1'b1, REFRESH_INT_OFS, 32'd40);
    rdc(MODE_IMAGE_OFS, 32'h0033);
    chk(32'(init_done), 32'h0);
    bus(1'b1, MODE_IMAGE_OFS, 32'hFFFF_FFFF);
    rdc(MODE_IMAGE_OFS, 32'h027F);
    bus(1'b1, MODE_IMAGE_OFS, 32'h022A);
    bus(1'b1, SEQ_STORE_LAST, 32'h1FFF);
    rdc(SEQ_STORE_LAST, 32'h1FFF);
    bus(1'b1, 12'h300, 32'h1234); // Unmapped write ignored
    rdc(12'h300, 32'h0);
    for (int k = 0; k < 8; k++)
      bus(1'b1, SEQ_STORE_BASE + 12'(4 * idx[k]), {19'h0, args[k], ops[k], 3'(idx[k]), 1'b0});
    rdc(SEQ_STORE_BASE + 12'h010, {19'h0, 6'h6, SDSC_OP_LOOP, 3'h4, 1'b0});
    for (int i = 0; i < 200 && init_done !== 1'b1; i++)
      @(posedge clk);
    chk(32'(init_done), 32'h1);
    repeat (50) @(posedge clk);
    chk(32'(starts.size()), 32'h0);
    rdc(CMD_STATUS_OFS, 32'h0000_000A);
    bus(1'b1, CTRL_FLAGS_OFS, 32'h0);
    for (int i = 0; i < 300 && starts.size() < 4; i++)
      @(posedge clk);
    chk(32'((starts[3] - starts[2]) / 25), 32'd40);
    for (int k = 0; k < 8; k++) begin
      chk(32'(steps[k]), {23'h0, ops[k], args[k]});
      chk(32'(i_sdsc_sdram_model.cmd_log[k]), 32'(idx[k][2:0]));
    end
    chk(32'(i_sdsc_sdram_model.mrs_image), 32'h00AA);
    chk(32'(i_sdsc_sdram_model.bad_cl), 32'h0);
    tally_and_finish;
  end
endmodule // test_sdram_sequencer_config
